// >>> tile_pkg.sv
// Constants and types for the surface tiling address unit
package tile_pkg;
   // Tile geometry
   localparam int TILE_BYTES_LOG2 = 12;
   localparam int HWALK_WIDTH_LOG2 = 9;
   localparam int HWALK_ROWS_LOG2 = 3;
   localparam int VWALK_WIDTH_LOG2 = 7;
   localparam int VWALK_ROWS_LOG2 = 5;
   localparam int VWALK_UNIT_LOG2 = 4;
   localparam int ADDR_W = 32;
   localparam int PITCH_W = 10;
   localparam int FENCE_COUNT = 16;
   // Walk encodings
   localparam logic WALK_HORIZONTAL = 1'h0;
   localparam logic WALK_VERTICAL = 1'h1;
   localparam logic FENCE_REGION_ABSENT = 1'h0;
   // Client identifiers
   typedef enum logic [2:0] {
      CLIENT_HOST,
      CLIENT_DISPLAY,
      CLIENT_BLIT,
      CLIENT_SAMPLER,
      CLIENT_COLOR,
      CLIENT_DEPTH
   } client_type;
   // Register map, word aligned byte addresses
   localparam logic [7:0] FENCE_BASE_OFS = 8'h00;
   localparam logic [7:0] FENCE_CTRL_OFS = 8'h40;
   localparam logic [7:0] STATUS_OFS = 8'h80;
   localparam logic [7:0] ERR_COUNT_OFS = 8'h84;
   localparam logic [31:0] UNMAPPED_DATA = 32'hDEAD_BEEF;
   // Fence control field positions
   localparam int FCTRL_VALID_BIT = 0;
   localparam int FCTRL_WALK_BIT = 1;
   localparam int FCTRL_PITCH_LSB = 2;
   localparam int FCTRL_LIMIT_LSB = 12;
endpackage

// >>> tile_xform_if.sv
// Request and result bundle between the unit and its tiling transform
`timescale 1ns/100ps
interface tile_xform_if;
   logic [31:0] offset;
   logic        tiled;
   logic        walk;
   logic [9:0]  pitch;
   logic [31:0] result;
   modport user (output offset, tiled, walk, pitch, input result);
   modport xform (input offset, tiled, walk, pitch, output result);
endinterface

// >>> tile_xform.sv
// Combinational linear to tiled offset transform
`timescale 1ns/100ps
module tile_xform (
   tile_xform_if.xform x
);
   import tile_pkg::*;

   // Pitch in bytes, field counts 128 byte units minus one
   // Sum kept 11 bits wide so the top code gives 128KB, not zero
   wire [31:0] pitch_bytes = {14'h0000, {1'b0, x.pitch} + 11'h001, 7'h00};
   // Row of bytes and column within row
   wire [31:0] line_num = x.offset / pitch_bytes;
   wire [31:0] line_col = x.offset % pitch_bytes;
   // Horizontal walk decomposition
   wire [31:0] h_tile_row = line_num >> HWALK_ROWS_LOG2;
   wire [31:0] h_in_row = line_num & 32'h0000_0007;
   wire [31:0] h_tile_col = line_col >> HWALK_WIDTH_LOG2;
   wire [31:0] h_in_col = line_col & 32'h0000_01FF;
   wire [31:0] h_tiles_per_row = pitch_bytes >> HWALK_WIDTH_LOG2;
   // Vertical walk decomposition
   wire [31:0] v_tile_row = line_num >> VWALK_ROWS_LOG2;
   wire [31:0] v_in_row = line_num & 32'h0000_001F;
   wire [31:0] v_tile_col = line_col >> VWALK_WIDTH_LOG2;
   wire [31:0] v_in_col = line_col & 32'h0000_007F;
   wire [31:0] v_tiles_per_row = pitch_bytes >> VWALK_WIDTH_LOG2;
   wire [31:0] h_addr;
   wire [31:0] v_addr;

   // Horizontal: 32 byte units run along X inside a 512x8 tile
   assign h_addr = ((h_tile_row * h_tiles_per_row + h_tile_col)
                    << TILE_BYTES_LOG2)
                 + (h_in_row << HWALK_WIDTH_LOG2) + h_in_col;
   // Vertical: 16 byte units run along Y inside a 128x32 tile
   assign v_addr = ((v_tile_row * v_tiles_per_row + v_tile_col)
                    << TILE_BYTES_LOG2)
                 + ((v_in_col >> VWALK_UNIT_LOG2) << (VWALK_ROWS_LOG2
                    + VWALK_UNIT_LOG2))
                 + (v_in_row << VWALK_UNIT_LOG2)
                 + (v_in_col & 32'h0000_000F);
   // Linear passes through, walk picks the layout
   assign x.result = !x.tiled ? x.offset
                   : (x.walk == WALK_VERTICAL) ? v_addr : h_addr;
endmodule

// >>> tile_addr_unit.sv
// Tiling detection and tiled address generation for graphics surfaces
//
// Functional notes
// - A fence with its valid flag clear defines no region and tiles nothing.
// - Internal clients take tiling only from per-surface parameters.
// - Tiled enable set means tiled access, clear means linear access.
// - Tile walk selects vertical or horizontal tile layout when tiled.
// - Client base passes untiled; only the X,Y offset is transformed.
// - Host address inside a fence is tiled whole from the fence base.
// - Tile row starts are fence base plus multiples of pitch times 4KB.
// - Display and overlay refuse vertical walk; async flips need horizontal.
// - Block transfer supports linear and horizontal walk only.
// - Sampler accepts every layout combination.
// - Color and depth accept any layout pairing.
// - A tile is 4KB: 512 bytes by 8 or 128 bytes by 32.
// - Walk 0 is horizontal with 32 byte units, 1 vertical with 16 byte.
// - Fences are masked for all internal client accesses.
//
// Added by the designer: the address map and the Wishbone slave port.
`timescale 1ns/100ps
module tile_addr_unit (
   input  wire logic                  core_clk,
   input  wire logic                  rst_n,
   // Wishbone slave
   input  wire logic                  wb_cyc_i,
   input  wire logic                  wb_stb_i,
   input  wire logic                  wb_we_i,
   input  wire logic [7:0]            wb_adr_i,
   input  wire logic [3:0]            wb_sel_i,
   input  wire logic [31:0]           wb_dat_i,
   output logic      [31:0]           wb_dat_o,
   output logic                       wb_ack_o,
   // Translation request
   input  wire logic                  req_valid,
   input  wire tile_pkg::client_type  req_client,
   input  wire logic [31:0]           req_addr,
   input  wire logic [31:0]           surf_base,
   input  wire logic                  surf_tiled,
   input  wire logic                  surf_walk,
   input  wire logic [9:0]            surf_pitch,
   input  wire logic                  async_flip,
   // Translation result
   output logic                       rsp_valid,
   output logic [31:0]                rsp_addr,
   output logic                       rsp_fenced,
   output logic                       rsp_refused
);
   import tile_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Fence registers: base word and control word per fence
   logic [31:0] fbase_reg [FENCE_COUNT];
   logic [31:0] fctrl_reg [FENCE_COUNT];
   logic [15:0] err_count_reg;
   logic        ack_reg;
   logic [31:0] rdata_reg;
   logic        rsp_valid_reg;
   logic [31:0] rsp_addr_reg;
   logic        rsp_fenced_reg;
   logic        rsp_refused_reg;

   // Merge write data under byte lanes
   function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  sel);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Bus decode
   wire       bus_req = wb_cyc_i && wb_stb_i && !ack_reg;
   wire       hit_base = wb_adr_i[7:6] == FENCE_BASE_OFS[7:6];
   wire       hit_ctrl = wb_adr_i[7:6] == FENCE_CTRL_OFS[7:6];
   wire [3:0] fsel = wb_adr_i[5:2];
   wire       hit_status = wb_adr_i == STATUS_OFS;
   wire       hit_err = wb_adr_i == ERR_COUNT_OFS;
   wire       wr_base = bus_req && wb_we_i && hit_base;
   wire       wr_ctrl = bus_req && wb_we_i && hit_ctrl;

   // Read data mux
   logic [31:0] rd_mux;
   always_comb begin
      if (hit_base) begin
         rd_mux = fbase_reg[fsel];
      end else if (hit_ctrl) begin
         rd_mux = fctrl_reg[fsel];
      end else if (hit_status) begin
         rd_mux = {29'h0000_0000, rsp_refused_reg, rsp_fenced_reg,
                   rsp_valid_reg};
      end else if (hit_err) begin
         rd_mux = {16'h0000, err_count_reg};
      end else begin
         rd_mux = UNMAPPED_DATA;
      end
   end

   // Register writes and one-cycle ack
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < FENCE_COUNT; i++) begin
            fbase_reg[i] <= 32'h0000_0000;
            fctrl_reg[i] <= 32'h0000_0000;
         end
         ack_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
      end else begin
         ack_reg <= bus_req;
         if (bus_req) begin
            rdata_reg <= rd_mux;
         end
         if (wr_base) begin
            fbase_reg[fsel] <= lane_merge(fbase_reg[fsel], wb_dat_i,
                                          wb_sel_i) & 32'hFFFF_F000;
         end
         if (wr_ctrl) begin
            fctrl_reg[fsel] <= lane_merge(fctrl_reg[fsel], wb_dat_i,
                                          wb_sel_i) & 32'hFFFF_FFFF;
         end
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = rdata_reg;

   ////////////////////////////////////////////////////////////////////////
   // Fence match for host accesses
   logic [FENCE_COUNT-1:0] fhit;
   for (genvar g = 0; g < FENCE_COUNT; g++) begin : g_match
      wire [31:0] lim = {fctrl_reg[g][31:FCTRL_LIMIT_LSB], 12'hFFF};
      assign fhit[g] = (fctrl_reg[g][FCTRL_VALID_BIT] != FENCE_REGION_ABSENT)
                     && (req_addr >= fbase_reg[g])
                     && (req_addr <= lim);
   end

   // Lowest matching fence wins; overlap is undefined anyway
   logic [3:0] fidx;
   logic       fany;
   always_comb begin
      fidx = 4'h0;
      fany = 1'b0;
      for (int i = FENCE_COUNT - 1; i >= 0; i--) begin
         if (fhit[i]) begin
            fidx = 4'(i);
            fany = 1'b1;
         end
      end
   end

   // Fences only count for the host, masked for internal clients
   wire is_host = req_client == CLIENT_HOST;
   wire use_fence = is_host && fany;
   wire [31:0] fctl = fctrl_reg[fidx];

   ////////////////////////////////////////////////////////////////////////
   // Per client layout support
   wire layout_ok;
   assign layout_ok =
      (req_client == CLIENT_DISPLAY)
         ? !(surf_tiled && surf_walk == WALK_VERTICAL)
           && !(async_flip && !(surf_tiled
                && surf_walk == WALK_HORIZONTAL))
      : (req_client == CLIENT_BLIT)
         ? !(surf_tiled && surf_walk == WALK_VERTICAL)
      : 1'b1; // Sampler, color, depth take any layout

   ////////////////////////////////////////////////////////////////////////
   // Transform setup: fence offset for host, surface offset for clients
   tile_xform_if xf ();

   assign xf.offset = use_fence ? req_addr - fbase_reg[fidx]
                                : req_addr;
   assign xf.tiled = use_fence ? 1'b1 : (!is_host && surf_tiled);
   assign xf.walk = use_fence ? fctl[FCTRL_WALK_BIT] : surf_walk;
   assign xf.pitch = use_fence ? fctl[FCTRL_PITCH_LSB +: PITCH_W]
                               : surf_pitch;

   tile_xform u_xform (
      .x (xf)
   );

   // Rebase: fence base for host, untiled surface base for clients
   wire [31:0] final_addr = use_fence ? fbase_reg[fidx] + xf.result
                          : is_host ? req_addr
                          : surf_base + xf.result;
   wire refuse = !is_host && !layout_ok;

   ////////////////////////////////////////////////////////////////////////
   // Registered response, one cycle after the request
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rsp_valid_reg <= 1'b0;
         rsp_addr_reg <= 32'h0000_0000;
         rsp_fenced_reg <= 1'b0;
         rsp_refused_reg <= 1'b0;
         err_count_reg <= 16'h0000;
      end else begin
         rsp_valid_reg <= req_valid;
         if (req_valid) begin
            rsp_addr_reg <= refuse ? 32'h0000_0000 : final_addr;
            rsp_fenced_reg <= use_fence;
            rsp_refused_reg <= refuse;
            if (refuse && err_count_reg != 16'hFFFF) begin
               err_count_reg <= err_count_reg + 16'h0001;
            end
         end
      end
   end

   assign rsp_valid = rsp_valid_reg;
   assign rsp_addr = rsp_addr_reg;
   assign rsp_fenced = rsp_fenced_reg;
   assign rsp_refused = rsp_refused_reg;
endmodule

// >>> tile_addr_unit_sva.sv
// Port checker for the surface tiling address unit
`timescale 1ns/100ps
module tile_addr_unit_sva (
   input wire logic                 core_clk,
   input wire logic                 rst_n,
   input wire logic                 wb_cyc_i,
   input wire logic                 wb_stb_i,
   input wire logic                 wb_we_i,
   input wire logic [7:0]           wb_adr_i,
   input wire logic [31:0]          wb_dat_o,
   input wire logic                 wb_ack_o,
   input wire logic                 req_valid,
   input wire tile_pkg::client_type req_client,
   input wire logic [31:0]          req_addr,
   input wire logic [31:0]          surf_base,
   input wire logic                 surf_tiled,
   input wire logic                 surf_walk,
   input wire logic                 async_flip,
   input wire logic                 rsp_valid,
   input wire logic [31:0]          rsp_addr,
   input wire logic                 rsp_fenced,
   input wire logic                 rsp_refused
);
   import tile_pkg::*;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // Steps of a bus access and of a request
   sequence s_take;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_stray;
      wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && wb_adr_i == 8'h90;
   endsequence
   sequence s_req(client_type c);
      req_valid && req_client == c;
   endsequence
   ////////////////////////////////////////////////////////////////////////
   a_ack_pulse: assert property (s_take |=> wb_ack_o ##1 !wb_ack_o)
      else $error("ack timing");
   a_stray_read: assert property (s_stray |=> wb_dat_o == UNMAPPED_DATA)
      else $error("unmapped read data");
   a_rsp_latency: assert property (req_valid |=> rsp_valid)
      else $error("no answer");
   a_rsp_hold: assert property (!req_valid |=> !rsp_valid && $stable(rsp_addr))
      else $error("answer not held");
   a_disp_vertical: assert property (req_valid
      && req_client == CLIENT_DISPLAY && surf_tiled && surf_walk
      |=> rsp_refused && rsp_addr == 32'h0)
      else $error("display vertical taken");
   a_flip_horiz: assert property (req_valid
      && req_client == CLIENT_DISPLAY && async_flip
      && !(surf_tiled && !surf_walk) |=> rsp_refused)
      else $error("flip layout taken");
   a_blit_vertical: assert property (req_valid
      && req_client == CLIENT_BLIT && surf_tiled && surf_walk
      |=> rsp_refused)
      else $error("blit vertical taken");
   a_sampler_all: assert property (s_req(CLIENT_SAMPLER)
      |=> !rsp_refused)
      else $error("sampler refused");
   a_render_all: assert property (req_valid
      && (req_client == CLIENT_COLOR || req_client == CLIENT_DEPTH)
      |=> !rsp_refused)
      else $error("render target refused");
   a_client_unfenced: assert property (req_valid
      && req_client != CLIENT_HOST |=> !rsp_fenced)
      else $error("client fenced");
   a_linear_pass: assert property (s_req(CLIENT_SAMPLER)
      ##0 !surf_tiled
      |=> rsp_addr == $past(surf_base) + $past(req_addr))
      else $error("linear address");
endmodule
bind tile_addr_unit tile_addr_unit_sva u_tile_addr_unit_sva (
   .core_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o,
   .wb_ack_o, .req_valid, .req_client, .req_addr, .surf_base, .surf_tiled,
   .surf_walk, .async_flip, .rsp_valid, .rsp_addr, .rsp_fenced, .rsp_refused);

// >>> tile_client_model.sv
// Request side model of host and graphics clients
`timescale 1ns/100ps
module tile_client_model (
   input  wire logic            core_clk,
   output logic                 req_valid,
   output tile_pkg::client_type req_client,
   output logic [31:0]          req_addr,
   output logic [31:0]          surf_base,
   output logic                 surf_tiled,
   output logic                 surf_walk,
   output logic [9:0]           surf_pitch,
   output logic                 async_flip
);
   import tile_pkg::*;
   // Idle before the first request
   initial begin
      req_valid = 1'b0;
      req_client = CLIENT_HOST;
      {req_addr, surf_base} = '0;
      {surf_tiled, surf_walk, surf_pitch, async_flip} = '0;
   end
   // One request cycle, then address and base turn to noise
   task automatic send(input client_type c, input logic [31:0] a, b,
                       input logic t, w, input logic [9:0] p, input logic f);
      @(posedge core_clk);
      req_valid <= 1'b1;
      req_client <= c;
      req_addr <= a;
      surf_base <= {b[31:12], 12'h000};
      {surf_tiled, surf_walk} <= {t, w};
      surf_pitch <= p;
      async_flip <= f;
      @(posedge core_clk);
      req_valid <= 1'b0;
      req_addr <= ~a;
      surf_base <= ~b;
   endtask
endmodule

// >>> test_tile_addr_unit.sv
// Self-checking testbench for the surface tiling address unit
`timescale 1ns/100ps
module test_tile_addr_unit;
   import tile_pkg::*;
   localparam logic [31:0] FBASE = 32'h0010_0000;
   logic        core_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic        req_valid, surf_tiled, surf_walk, async_flip;
   logic        rsp_valid, rsp_fenced, rsp_refused;
   logic [7:0]  wb_adr_i;
   logic [3:0]  wb_sel_i;
   logic [9:0]  surf_pitch;
   logic [31:0] wb_dat_i, wb_dat_o, req_addr, surf_base, rsp_addr;
   client_type  req_client;
   logic [33:0] rq[$];
   logic [31:0] bq[$];
   int          n_errors = 0, comparisons = 0, n_ref = 0;
   // Unit and client model
   tile_addr_unit u_tile_addr_unit (
      .core_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
      .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .req_valid,
      .req_client, .req_addr, .surf_base, .surf_tiled, .surf_walk,
      .surf_pitch, .async_flip, .rsp_valid, .rsp_addr, .rsp_fenced,
      .rsp_refused);
   tile_client_model u_tile_client_model (
      .core_clk, .req_valid, .req_client, .req_addr, .surf_base,
      .surf_tiled, .surf_walk, .surf_pitch, .async_flip);
   // Core clock
   initial core_clk = 1'b0;
   always #5 core_clk = ~core_clk;
   ////////////////////////////////////////////////////////////////////////
   task automatic final_report;
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic check(input logic [33:0] got, exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Watcher takes the oldest note per result
   always @(posedge core_clk) begin
      if (rsp_valid === 1'b1)
         check({rsp_addr, rsp_fenced, rsp_refused}, rq.pop_front());
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
         check({2'b00, wb_dat_o}, {2'b00, bq.pop_front()});
   end
   // Classic bus cycle held until ack
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] s = 4'hF);
      @(posedge core_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_sel_i <= s;
      wb_dat_i <= d;
      do @(posedge core_clk); while (wb_ack_o !== 1'b1);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bq.push_back(e);
      wb(1'b0, a, 32'h0);
   endtask
   task automatic go(input client_type c, input logic [31:0] a, b,
      input logic t, w, input logic [9:0] p, input logic f,
      input logic [33:0] e);
      rq.push_back(e);
      u_tile_client_model.send(c, a, b, t, w, p, f);
   endtask
   task automatic host(input logic [31:0] a, input logic [33:0] e);
      go(CLIENT_HOST, a, 32'h0, 1'b0, 1'b0, 10'h0, 1'b0, e);
   endtask
   // Expected tiled offset
   function automatic logic [31:0] tmap(logic [31:0] o, logic w,
                                        logic [9:0] p);
      int unsigned pb, ln, cl;
      pb = (p + 1) * 128;
      ln = o / pb;
      cl = o % pb;
      if (!w)
         return ((ln >> 3) * (pb / 512) + (cl >> 9)) * 4096 + (ln & 7) * 512
            + (cl & 511);
      return ((ln >> 5) * (pb / 128) + (cl >> 7)) * 4096
         + ((cl & 127) >> 4) * 512 + (ln & 31) * 16 + (cl & 15);
   endfunction
   function automatic logic [33:0] expc(client_type c, logic [31:0] a, b,
      logic t, w, logic [9:0] p, logic f);
      if (c == CLIENT_DISPLAY && (t && w || f && !(t && !w))
          || c == CLIENT_BLIT && t && w)
         return 34'h1;
      return {b + (t ? tmap(a, w, p) : a), 2'b00};
   endfunction
   // Hang guard
   initial begin
      #100_000;
      n_errors++;
      final_report();
   end
   // Main sequence
   initial begin
      logic [31:0] a, b, r;
      logic [9:0]  p;
      logic        t, w, f;
      client_type  c;
      logic [33:0] e;
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
      rst_n = 1'b0;
      void'($urandom(32'h3637));
      repeat (6) @(posedge core_clk);
      rst_n <= 1'b1;
      rd(FENCE_CTRL_OFS, 32'h0);
      wb(1'b1, 8'h90, 32'h1234_5678);
      rd(8'h90, UNMAPPED_DATA);
      // One byte lane only, low page bits stay zero
      wb(1'b1, FENCE_BASE_OFS, 32'h1234_5678, 4'h4);
      rd(FENCE_BASE_OFS, 32'h0034_0000);
      host(FBASE, {FBASE, 2'b00});
      $display("test reset done");
      for (int k = 0; k < 2; k++) begin
         p = k ? 10'h005 : 10'h007;
         r = (p + 1) * 128 / (k ? 128 : 512) * 4096;
         wb(1'b1, FENCE_BASE_OFS, FBASE);
         wb(1'b1, FENCE_CTRL_OFS, {20'h0_010F, p, k[0], 1'b1});
         repeat (6) begin
            a = FBASE + $urandom % 32'h1_0000;
            host(a, {FBASE + tmap(a - FBASE, k[0], p), 2'b10});
         end
         host(FBASE + 2 * r, {FBASE + 2 * r, 2'b10});
         host(FBASE + 32'h1_0000, {FBASE + 32'h1_0000, 2'b00});
         go(CLIENT_SAMPLER, a, 32'h0020_0000, 1'b0, 1'b0, 10'h0, 1'b0,
            {32'h0020_0000 + a, 2'b00});
         // Shared surface at the fence base, same pitch and walk
         go(CLIENT_SAMPLER, a - FBASE, FBASE, 1'b1, k[0], p, 1'b0,
            {FBASE + tmap(a - FBASE, k[0], p), 2'b00});
         $display("test fence walk %0d done", k);
      end
      repeat (40) begin
         c = client_type'(1 + $urandom % 5);
         {t, w, f} = 3'($urandom); // Narrow formats only
         p = w ? 10'($urandom % 64) : {6'($urandom % 16), 2'b11};
         a = $urandom % 32'h1_0000;
         b = $urandom & 32'hFFFF_F000;
         e = expc(c, a, b, t, w, p, f);
         n_ref += e[0];
         go(c, a, b, t, w, p, f, e);
      end
      rd(STATUS_OFS, {29'h0000_0000, e[0], e[1], 1'b0});
      rd(ERR_COUNT_OFS, n_ref);
      $display("test clients done");
      wb(1'b1, FENCE_CTRL_OFS, {20'h0_010F, 10'h007, 2'b00});
      host(FBASE + 32'h200, {FBASE + 32'h200, 2'b00});
      repeat (4) @(posedge core_clk);
      // Every noted result must have come back
      check(34'(rq.size() + bq.size()), 34'h0);
      $display("test fence off done");
      final_report();
   end
endmodule
